// File: rtl/usc_defs.svh
// Register addresses, field positions, reset values and counts
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH

`define USC_CSM_ADDR 16'hff72
`define USC_ASM_ADDR 16'hffa0
`define USC_BRG_ADDR 16'hffa1
`define USC_ARS_ADDR 16'hffa3
`define USC_DATA_ADDR 16'hffa2
`define USC_CSD_ADDR 16'hff74

`define USC_CSM_RST 8'h00
`define USC_ASM_RST 8'h00
`define USC_BRG_RST 8'h00
`define USC_ARS_RST 8'h00
`define USC_TXH_RST 8'hff
`define USC_BUF_RST 8'h00

`define USC_CSM_MASK 8'h96
`define USC_ASM_MASK 8'hfe
`define USC_BRG_MASK 8'h7f

`define USC_CSM_EN 7
`define USC_CSM_PRE 4
`define USC_CSM_DIR 2
`define USC_CSM_SRC 1

`define USC_ASM_TXE 7
`define USC_ASM_RXE 6
`define USC_ASM_PAR_HI 5
`define USC_ASM_PAR_LO 4
`define USC_ASM_CL 3
`define USC_ASM_SL 2
`define USC_ASM_ISRM 1

`define USC_BRG_N_HI 6
`define USC_BRG_N_LO 4
`define USC_BRG_K_HI 3
`define USC_BRG_K_LO 0

`define USC_ARS_PE 2
`define USC_ARS_FE 1
`define USC_ARS_OVE 0

`define USC_BASE_DIV 5'h10
`define USC_SCK_HALF_DIV4 2'h1
`define USC_SCK_HALF_DIV8 2'h3

`endif

// File: rtl/usc_pkg.sv
// Types shared by the serial control block
package usc_pkg;

	typedef enum logic [1:0] {
		USC_PAR_NONE,
		USC_PAR_ZERO,
		USC_PAR_ODD,
		USC_PAR_EVEN
	} usc_parity_t;

	typedef enum logic [2:0] {
		USC_TX_IDLE,
		USC_TX_START,
		USC_TX_DATA,
		USC_TX_PAR,
		USC_TX_STOP1,
		USC_TX_STOP2
	} usc_tx_state_t;

	typedef enum logic [2:0] {
		USC_RX_IDLE,
		USC_RX_START,
		USC_RX_DATA,
		USC_RX_PAR,
		USC_RX_STOP
	} usc_rx_state_t;

endpackage

// File: rtl/usc_baud.sv
// Prescaler that makes the source strobe of the baud counters
`timescale 1ns/1ns
`default_nettype none

module usc_baud (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       clk_en,
	input  wire logic       run,
	input  wire logic [2:0] n_sel,
	output logic            src_tick
);

	logic [8:0] pre_r;
	logic [8:0] mask;

	// Period of the strobe is 2 to the power n+1, n = n_sel+1
	assign mask = 9'h1ff >> (3'h7 - n_sel); // R19

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pre_r    <= 9'h000;
			src_tick <= 1'h0;
		end else if (clk_en) begin
			if (!run) begin
				pre_r    <= 9'h000;
				src_tick <= 1'h0;
			end else begin
				pre_r    <= pre_r + 9'h001;
				src_tick <= (pre_r & mask) == mask; // R19
			end
		end
	end

endmodule

`default_nettype wire

// File: rtl/usc_rx.sv
// Asynchronous receiver: start check, data, parity, one stop bit
`timescale 1ns/1ns
`default_nettype none

module usc_rx
	import usc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic        enable,
	input  wire logic        src_tick,
	input  wire logic [4:0]  half_len,
	input  wire logic        char8,
	input  wire usc_parity_t parity_mode,
	input  wire logic        rxd,
	output logic             done,
	output logic [7:0]       data,
	output logic             parity_err,
	output logic             frame_err
);

	usc_rx_state_t state_r;
	logic [5:0]    tick_r;
	logic [2:0]    bit_r;
	logic [7:0]    sr_r;
	logic          par_r;
	logic [5:0]    goal;
	logic          at_goal;
	logic          last_bit;
	logic          rxd_prev_r;

	// Start waits half a bit so later samples fall mid-bit
	assign goal = (state_r == USC_RX_START) ?
		({1'h0, half_len} - 6'h01) : ({half_len, 1'h0} - 6'h01);
	assign at_goal  = src_tick && (tick_r == goal);
	assign last_bit = bit_r == (char8 ? 3'h7 : 3'h6);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tick_r <= 6'h00;
		end else if (clk_en) begin
			if (state_r == USC_RX_IDLE || at_goal)
				tick_r <= 6'h00;
			else if (src_tick)
				tick_r <= tick_r + 6'h01;
		end
	end

	// Start needs a falling edge, so a low stop bit is not a new start
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			rxd_prev_r <= 1'h1;
		else if (clk_en)
			rxd_prev_r <= rxd;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_r    <= USC_RX_IDLE;
			bit_r      <= 3'h0;
			sr_r       <= 8'h00;
			par_r      <= 1'h0;
			done       <= 1'h0;
			data       <= 8'h00;
			parity_err <= 1'h0;
			frame_err  <= 1'h0;
		end else if (clk_en) begin
			done <= 1'h0;
			if (!enable) begin
				state_r <= USC_RX_IDLE;
			end else begin
				unique case (state_r)
				USC_RX_IDLE: begin
					parity_err <= parity_err;
					if (rxd_prev_r && !rxd)
						state_r <= USC_RX_START; // R25
				end
				USC_RX_START: begin
					if (at_goal) begin
						// A glitch shorter than half a bit is dropped
						state_r <= rxd ? USC_RX_IDLE : USC_RX_DATA;
						bit_r   <= 3'h0;
						par_r   <= 1'h0;
					end
				end
				USC_RX_DATA: begin
					if (at_goal) begin
						sr_r  <= {rxd, sr_r[7:1]}; // R25
						par_r <= par_r ^ rxd;
						bit_r <= bit_r + 3'h1;
						if (last_bit)
							state_r <= (parity_mode == USC_PAR_NONE) ?
								USC_RX_STOP : USC_RX_PAR;
					end
				end
				USC_RX_PAR: begin
					if (at_goal) begin
						state_r <= USC_RX_STOP;
						unique case (parity_mode)
						USC_PAR_ODD:  parity_err <= !(par_r ^ rxd); // R8 R15
						USC_PAR_EVEN: parity_err <= par_r ^ rxd; // R8 R15
						USC_PAR_NONE,
						USC_PAR_ZERO: parity_err <= 1'h0; // R8
						endcase
					end
				end
				USC_RX_STOP: begin
					// Only the first stop bit is looked at
					if (at_goal) begin
						state_r   <= USC_RX_IDLE;
						frame_err <= !rxd; // R10 R16
						done      <= 1'h1;
						data      <= char8 ? sr_r : {1'h0, sr_r[7:1]}; // R24
						if (parity_mode == USC_PAR_NONE)
							parity_err <= 1'h0;
					end
				end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// File: rtl/usc_top.sv
// Dual-mode serial control: registers, transmitter, 3-wire shifter
`timescale 1ns/1ns
`default_nettype none
`include "usc_defs.svh"

// Function
// R1 - Clocked-serial enable bit stops 3-wire operation at 0, enables at 1.
// R2 - Internal shift clock is system clock divided by 4 or by 8.
// R3 - Bit-order bit: 0 sends most significant bit first, 1 least.
// R4 - Clock source bit: 0 uses external clock pin, 1 internal clock.
// R5 - Software writes zero to bits 0, 3, 5, 6 of clocked mode.
// R6 - Software keeps clocked mode register zero while in asynchronous mode.
// R7 - Async mode bit 7 enables transmit, bit 6 enables receive.
// R8 - Parity: none, fixed zero unchecked, odd, or even.
// R9 - Length bit picks 7 or 8 data bits; stop bit picks 1 or 2.
// R10 - Receiver checks only one stop bit whatever the stop setting.
// R11 - Error mask bit 1 suppresses completion request on erroneous reception.
// R12 - Software keeps async bit 0 zero, register zero in 3-wire mode.
// R13 - Software stops transfers before changing the operating mode.
// R14 - In 3-wire transmit-only use, serial input pin is released.
// R15 - Parity error flag is status bit 2, set on parity mismatch.
// R16 - Framing error flag is status bit 1, set on missing stop.
// R17 - Overrun flag is status bit 0, set when buffer was unread.
// R18 - Unread buffer makes every later character flag overrun again.
// R19 - Baud bits 6 to 4 pick source clock: system over 2^(n+1).
// R20 - Baud bits 3 to 0 divide the source clock by k+16.
// R21 - Bit rate is system clock over 2^(n+2) times (k+16).
// R22 - Software keeps baud bit 7 zero, never writes during transfer.
// R23 - Writing transmit data starts sending; 7-bit mode sends bits 0-6.
// R24 - In 7-bit mode received data sits low, top bit reads zero.
// R25 - Frame: low start, data LSB first, optional parity, high stops.
module usc_top
	import usc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic [15:0] bus_addr,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [7:0]  bus_wdata,
	output logic [7:0]       bus_rdata,
	output logic             async_transmit_pin,
	output logic             async_transmit_oe,
	input  wire logic        async_receive_pin,
	input  wire logic        serial_clock_in,
	output logic             serial_clock_out,
	output logic             serial_clock_oe,
	input  wire logic        clocked_serial_in_pin,
	output logic             clocked_serial_out_pin,
	output logic             clocked_serial_out_oe,
	output logic             serial_in_claimed,
	output logic             rx_complete,
	output logic             tx_complete,
	output logic             csi_complete
);

	logic [7:0]    csm_r;
	logic [7:0]    asm_r;
	logic [7:0]    brg_r;
	logic [7:0]    ars_r;
	logic [7:0]    txh_r;
	logic [7:0]    rxbuf_r;
	logic [7:0]    csd_r;
	logic          rx_full_r;
	logic          rx_irq_r;
	logic [2:0]    sync1_r;
	logic [2:0]    sync2_r;
	logic          wr_csm;
	logic          wr_asm;
	logic          wr_brg;
	logic          wr_data;
	logic          wr_csd;
	logic          rd_data;
	logic          csi_en;
	logic          csi_pre;
	logic          csi_dir;
	logic          csi_int;
	logic          tx_en;
	logic          rx_en;
	usc_parity_t   par_mode;
	logic          char8;
	logic          stop2;
	logic          err_mask;
	logic [4:0]    half_len;
	logic          src_tick;
	logic          rxd_s;
	logic          sck_s;
	logic          si_s;

	assign wr_csm  = bus_wr && bus_addr == `USC_CSM_ADDR;
	assign wr_asm  = bus_wr && bus_addr == `USC_ASM_ADDR;
	assign wr_brg  = bus_wr && bus_addr == `USC_BRG_ADDR;
	assign wr_data = bus_wr && bus_addr == `USC_DATA_ADDR;
	assign wr_csd  = bus_wr && bus_addr == `USC_CSD_ADDR;
	assign rd_data = bus_rd && bus_addr == `USC_DATA_ADDR;

	assign csi_en   = csm_r[`USC_CSM_EN];
	assign csi_pre  = csm_r[`USC_CSM_PRE];
	assign csi_dir  = csm_r[`USC_CSM_DIR];
	assign csi_int  = csm_r[`USC_CSM_SRC];
	assign tx_en    = asm_r[`USC_ASM_TXE]; // R7
	assign rx_en    = asm_r[`USC_ASM_RXE]; // R7
	assign par_mode = usc_parity_t'(asm_r[`USC_ASM_PAR_HI:`USC_ASM_PAR_LO]);
	assign char8    = asm_r[`USC_ASM_CL]; // R9
	assign stop2    = asm_r[`USC_ASM_SL]; // R9
	assign err_mask = asm_r[`USC_ASM_ISRM];
	assign half_len = {1'h0, brg_r[`USC_BRG_K_HI:`USC_BRG_K_LO]}
		+ `USC_BASE_DIV; // R20

	assign rxd_s = sync2_r[2];
	assign sck_s = sync2_r[1];
	assign si_s  = sync2_r[0];

	// Pin inputs: only the second stage is read
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sync1_r <= 3'h7;
			sync2_r <= 3'h7;
		end else if (clk_en) begin
			sync1_r <= {async_receive_pin, serial_clock_in,
				clocked_serial_in_pin};
			sync2_r <= sync1_r;
		end
	end

	// Reserved bits are masked so they always read zero
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			csm_r <= `USC_CSM_RST;
			asm_r <= `USC_ASM_RST;
			brg_r <= `USC_BRG_RST;
		end else if (clk_en) begin
			if (wr_csm)
				csm_r <= bus_wdata & `USC_CSM_MASK;
			if (wr_asm)
				asm_r <= bus_wdata & `USC_ASM_MASK;
			if (wr_brg)
				brg_r <= bus_wdata & `USC_BRG_MASK;
		end
	end

	usc_baud u_baud (
		.ref_clk  (ref_clk),
		.resetn   (resetn),
		.clk_en   (clk_en),
		.run      (tx_en || rx_en),
		.n_sel    (brg_r[`USC_BRG_N_HI:`USC_BRG_N_LO]),
		.src_tick (src_tick)
	);

	// Transmitter
	usc_tx_state_t tx_state_r;
	logic [5:0]    tx_tick_r;
	logic [2:0]    tx_bit_r;
	logic          txd_r;
	logic          tx_done_r;
	logic          tx_end;
	logic          tx_dpar;
	logic          tx_pbit;

	// One bit lasts twice the k+16 count of source strobes
	assign tx_end  = src_tick &&
		tx_tick_r == ({half_len, 1'h0} - 6'h01); // R21
	assign tx_dpar = char8 ? ^txh_r : ^txh_r[6:0];
	assign tx_pbit = (par_mode == USC_PAR_ODD) ? !tx_dpar :
		(par_mode == USC_PAR_EVEN) ? tx_dpar : 1'h0; // R8

	// Writes while a frame is in flight are dropped
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			txh_r <= `USC_TXH_RST;
		else if (clk_en && wr_data && tx_en && tx_state_r == USC_TX_IDLE)
			txh_r <= bus_wdata; // R23
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_tick_r <= 6'h00;
		end else if (clk_en) begin
			if (tx_state_r == USC_TX_IDLE || tx_end)
				tx_tick_r <= 6'h00;
			else if (src_tick)
				tx_tick_r <= tx_tick_r + 6'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_state_r <= USC_TX_IDLE;
			tx_bit_r   <= 3'h0;
			txd_r      <= 1'h1;
			tx_done_r  <= 1'h0;
		end else if (clk_en) begin
			tx_done_r <= 1'h0;
			if (!tx_en) begin
				tx_state_r <= USC_TX_IDLE;
				txd_r      <= 1'h1;
			end else begin
				unique case (tx_state_r)
				USC_TX_IDLE: begin
					if (wr_data) begin
						tx_state_r <= USC_TX_START; // R23
						txd_r      <= 1'h0; // R25
					end
				end
				USC_TX_START: begin
					if (tx_end) begin
						tx_state_r <= USC_TX_DATA;
						tx_bit_r   <= 3'h0;
						txd_r      <= txh_r[0]; // R25
					end
				end
				USC_TX_DATA: begin
					if (tx_end) begin
						if (tx_bit_r == (char8 ? 3'h7 : 3'h6)) begin // R9 R23
							if (par_mode == USC_PAR_NONE) begin
								tx_state_r <= USC_TX_STOP1;
								txd_r      <= 1'h1;
							end else begin
								tx_state_r <= USC_TX_PAR;
								txd_r      <= tx_pbit; // R8
							end
						end else begin
							tx_bit_r <= tx_bit_r + 3'h1;
							txd_r    <= txh_r[tx_bit_r + 3'h1];
						end
					end
				end
				USC_TX_PAR: begin
					if (tx_end) begin
						tx_state_r <= USC_TX_STOP1;
						txd_r      <= 1'h1; // R25
					end
				end
				USC_TX_STOP1: begin
					if (tx_end) begin
						tx_state_r <= stop2 ? USC_TX_STOP2 : USC_TX_IDLE; // R9
						tx_done_r  <= !stop2;
					end
				end
				USC_TX_STOP2: begin
					if (tx_end) begin
						tx_state_r <= USC_TX_IDLE;
						tx_done_r  <= 1'h1;
					end
				end
				endcase
			end
		end
	end

	// Receiver and its status
	logic       rx_done;
	logic [7:0] rx_data;
	logic       rx_pe;
	logic       rx_fe;
	logic       rx_ove;

	usc_rx u_rx (
		.ref_clk     (ref_clk),
		.resetn      (resetn),
		.clk_en      (clk_en),
		.enable      (rx_en),
		.src_tick    (src_tick),
		.half_len    (half_len),
		.char8       (char8),
		.parity_mode (par_mode),
		.rxd         (rxd_s),
		.done        (rx_done),
		.data        (rx_data),
		.parity_err  (rx_pe),
		.frame_err   (rx_fe)
	);

	// A read in the same cycle counts as having emptied the buffer
	assign rx_ove = rx_full_r && !rd_data; // R17 R18

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rx_full_r <= 1'h0;
			rxbuf_r   <= `USC_BUF_RST;
			ars_r     <= `USC_ARS_RST;
			rx_irq_r  <= 1'h0;
		end else if (clk_en) begin
			rx_irq_r <= 1'h0;
			if (rx_done) begin
				rx_full_r          <= 1'h1; // R18
				rxbuf_r            <= rx_data;
				ars_r              <= `USC_ARS_RST;
				ars_r[`USC_ARS_PE]  <= rx_pe; // R15
				ars_r[`USC_ARS_FE]  <= rx_fe; // R16
				ars_r[`USC_ARS_OVE] <= rx_ove; // R17
				rx_irq_r <= !(err_mask && (rx_pe || rx_fe || rx_ove)); // R11
			end else if (rd_data) begin
				rx_full_r <= 1'h0; // R18
			end
		end
	end

	// 3-wire shifter
	logic       csi_busy_r;
	logic [2:0] csi_cnt_r;
	logic [1:0] csi_pre_r;
	logic       csi_sck_r;
	logic       csi_so_r;
	logic       csi_done_r;
	logic       sck_prev_r;
	logic [1:0] csi_half;
	logic       int_edge;
	logic       sh_fall;
	logic       sh_rise;

	assign csi_half = csi_pre ? `USC_SCK_HALF_DIV8 : `USC_SCK_HALF_DIV4; // R2
	assign int_edge = csi_busy_r && csi_int && csi_pre_r == csi_half;
	// External clock edges are taken only while a byte is pending
	assign sh_fall  = csi_int ? (int_edge && csi_sck_r) :
		(csi_busy_r && sck_prev_r && !sck_s); // R4
	assign sh_rise  = csi_int ? (int_edge && !csi_sck_r) :
		(csi_busy_r && !sck_prev_r && sck_s); // R4

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			csi_pre_r  <= 2'h0;
			csi_sck_r  <= 1'h1;
			sck_prev_r <= 1'h1;
		end else if (clk_en) begin
			sck_prev_r <= sck_s;
			if (!csi_busy_r || !csi_int) begin
				csi_pre_r <= 2'h0;
				csi_sck_r <= 1'h1;
			end else if (int_edge) begin
				csi_pre_r <= 2'h0;
				csi_sck_r <= !csi_sck_r; // R2
			end else begin
				csi_pre_r <= csi_pre_r + 2'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			csi_busy_r <= 1'h0;
			csi_cnt_r  <= 3'h0;
			csd_r      <= `USC_BUF_RST;
			csi_so_r   <= 1'h1;
			csi_done_r <= 1'h0;
		end else if (clk_en) begin
			csi_done_r <= 1'h0;
			if (!csi_en) begin
				csi_busy_r <= 1'h0; // R1
			end else if (!csi_busy_r) begin
				if (wr_csd) begin
					csd_r      <= bus_wdata; // R1
					csi_busy_r <= 1'h1;
					csi_cnt_r  <= 3'h0;
				end
			end else if (sh_fall) begin
				csi_so_r <= csi_dir ? csd_r[0] : csd_r[7]; // R3
			end else if (sh_rise) begin
				csd_r <= csi_dir ? {si_s, csd_r[7:1]} :
					{csd_r[6:0], si_s}; // R3
				csi_cnt_r <= csi_cnt_r + 3'h1;
				if (csi_cnt_r == 3'h7) begin
					csi_busy_r <= 1'h0;
					csi_done_r <= 1'h1;
				end
			end
		end
	end

	// Read port; unmapped addresses answer zero
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bus_rdata <= 8'h00;
		end else if (clk_en && bus_rd) begin
			case (bus_addr)
			`USC_CSM_ADDR:  bus_rdata <= csm_r;
			`USC_ASM_ADDR:  bus_rdata <= asm_r;
			`USC_BRG_ADDR:  bus_rdata <= brg_r;
			`USC_ARS_ADDR:  bus_rdata <= ars_r;
			`USC_DATA_ADDR: bus_rdata <= rxbuf_r;
			`USC_CSD_ADDR:  bus_rdata <= csd_r;
			default:        bus_rdata <= 8'h00;
			endcase
		end
	end

	assign async_transmit_pin     = txd_r;
	assign async_transmit_oe      = tx_en;
	assign clocked_serial_out_pin = csi_so_r;
	assign clocked_serial_out_oe  = csi_en;
	assign serial_clock_out       = csi_sck_r;
	assign serial_clock_oe        = csi_en && csi_int; // R4
	assign serial_in_claimed      = rx_en; // R14
	assign rx_complete            = rx_irq_r;
	assign tx_complete            = tx_done_r;
	assign csi_complete           = csi_done_r;

endmodule

`default_nettype wire

// File: test/usc_top_sva.sv
// Port-level assertions for the dual-mode serial control block
`timescale 1ns/1ns
`default_nettype none

module usc_chk (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic [15:0] bus_addr,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic [7:0]  bus_rdata,
	input  wire logic        async_transmit_pin,
	input  wire logic        async_transmit_oe,
	input  wire logic        serial_clock_oe,
	input  wire logic        clocked_serial_out_oe,
	input  wire logic        serial_in_claimed,
	input  wire logic        tx_complete
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic wr_asm, wr_csm;
	assign wr_asm = clk_en && bus_wr && bus_addr == 16'hffa0;
	assign wr_csm = clk_en && bus_wr && bus_addr == 16'hff72;
	property p_txe;
		wr_asm |=> async_transmit_oe == $past(bus_wdata[7]);
	endproperty
	a_txe: assert property (p_txe) else $error("tx enable wrong");
	property p_rxe;
		wr_asm |=> serial_in_claimed == $past(bus_wdata[6]);
	endproperty
	a_rxe: assert property (p_rxe) else $error("input claim wrong");
	property p_csie;
		wr_csm |=> clocked_serial_out_oe == $past(bus_wdata[7]);
	endproperty
	a_csie: assert property (p_csie) else $error("csi enable wrong");
	property p_sckoe;
		wr_csm |=> serial_clock_oe ==
			($past(bus_wdata[7]) && $past(bus_wdata[1]));
	endproperty
	a_sckoe: assert property (p_sckoe) else $error("sck drive wrong");
	property p_idle;
		!async_transmit_oe |=> async_transmit_pin;
	endproperty
	a_idle: assert property (p_idle) else $error("tx line not idle");
	property p_txc;
		tx_complete |-> async_transmit_pin ##1 !tx_complete;
	endproperty
	a_txc: assert property (p_txc) else $error("tx end wrong");
	property p_stat;
		clk_en && bus_rd && bus_addr == 16'hffa3 |=> bus_rdata[7:3] == 5'h00;
	endproperty
	a_stat: assert property (p_stat) else $error("status high bits set");
	property p_csm_rd;
		clk_en && bus_rd && bus_addr == 16'hff72 |=>
			(bus_rdata & 8'h69) == 8'h00;
	endproperty
	a_csm_rd: assert property (p_csm_rd) else $error("csi mode bits");
endmodule

bind usc_top usc_chk chk (
	.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
	.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.async_transmit_pin(async_transmit_pin),
	.async_transmit_oe(async_transmit_oe),
	.serial_clock_oe(serial_clock_oe),
	.clocked_serial_out_oe(clocked_serial_out_oe),
	.serial_in_claimed(serial_in_claimed), .tx_complete(tx_complete)
);

`default_nettype wire

// File: test/usc_remote.sv
// Remote UART: sends frames on the receive line, captures sent frames
`timescale 1ns/1ns
`default_nettype none

module usc_remote (
	input  wire logic ref_clk,
	input  wire logic txd,
	output logic      rxd
);
	initial rxd = 1'b1;

	task automatic send(input logic [11:0] f, input int nb, input int bt);
		int i;
		for (i = 0; i < nb; i++) begin
			rxd = f[i];
			repeat (bt) @(posedge ref_clk);
			#2;
		end
		rxd = 1'b1;
	endtask

	task automatic recv(output logic [11:0] f, input int nb, input int bt,
		output logic ok);
		int i, w;
		f = 12'hfff;
		w = 0;
		while (txd && w < 4000) begin
			@(posedge ref_clk);
			#2;
			w++;
		end
		ok = !txd;
		// Mid-bit sampling tolerates a short start bit
		repeat (bt / 2) @(posedge ref_clk);
		#2;
		for (i = 0; i < nb; i++) begin
			f[i] = txd;
			if (i < nb - 1) begin
				repeat (bt) @(posedge ref_clk);
				#2;
			end
		end
	endtask
endmodule

`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the dual-mode serial control block
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic        ref_clk, resetn, bus_wr, bus_rd, txd, rxd, so, sco;
	logic        txc, rxc, csc, sci;
	logic [15:0] bus_addr;
	logic [7:0]  bus_wdata, bus_rdata, asm_v, v;
	int          error_cnt = 0;
	int          num_checks = 0;
	logic [15:0] addrs [5] = '{16'hff72, 16'hffa0, 16'hffa1, 16'hffa3,
		16'h1234};
	logic [7:0]  masks [5] = '{8'h96, 8'hfe, 8'h7f, 8'h00, 8'h00};

	usc_top dut (
		.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
		.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.async_transmit_pin(txd), .async_transmit_oe(),
		.async_receive_pin(rxd), .serial_clock_in(sci),
		.serial_clock_out(sco), .serial_clock_oe(),
		.clocked_serial_in_pin(so), .clocked_serial_out_pin(so),
		.clocked_serial_out_oe(), .serial_in_claimed(),
		.rx_complete(rxc), .tx_complete(txc), .csi_complete(csc)
	);
	usc_remote rem (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task complete_run;
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [15:0] a, input logic [7:0] d);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(posedge ref_clk);
		#2 bus_wr = 1'b0;
		@(posedge ref_clk);
		#2;
	endtask

	task rd(input logic [15:0] a, output logic [7:0] d);
		bus_addr = a;
		bus_rd = 1'b1;
		@(posedge ref_clk);
		#2 bus_rd = 1'b0;
		d = bus_rdata;
		@(posedge ref_clk);
		#2;
	endtask

	task wait_pulse(input int sel, input int lim, output logic seen);
		int i;
		seen = 1'b0;
		for (i = 0; i < lim && !seen; i++) begin
			@(posedge ref_clk);
			#2;
			seen = sel == 0 ? txc : (sel == 1 ? rxc : csc);
		end
	endtask

	function automatic int bt(input logic [7:0] b);
		return 2 * (b[3:0] + 16) * (1 << (b[6:4] + 2));
	endfunction

	// Expected line bits, start bit first, stop bits padded high
	function automatic logic [11:0] frame(input logic [7:0] d, input logic c8,
		input logic [1:0] pm, input logic sl, output int nb);
		logic [7:0] m;
		int         i;
		m = c8 ? d : {1'b0, d[6:0]};
		frame = 12'hfff;
		frame[0] = 1'b0;
		nb = 1;
		for (i = 0; i < (c8 ? 8 : 7); i++) begin
			frame[nb] = m[i];
			nb++;
		end
		if (pm != 2'h0) begin
			frame[nb] = pm == 2'h1 ? 1'b0 : (pm == 2'h2 ? ~^m : ^m);
			nb++;
		end
		nb = nb + 1 + sl;
	endfunction

	task tx(input logic [7:0] m, input logic [7:0] b, input logic [7:0] d);
		logic [11:0] exp, got;
		int          nb;
		logic        ok;
		wr(16'hffa1, b);
		wr(16'hffa0, m);
		exp = frame(d, m[3], m[5:4], m[2], nb);
		wr(16'hffa2, d);
		rem.recv(got, nb, bt(b), ok);
		chk(got, exp);
		wait_pulse(0, bt(b), ok);
		chk(ok, 1'b1);
	endtask

	task rx(input logic [7:0] d, input logic [1:0] bad, input logic rdb,
		input logic [3:0] exp_st, input logic [7:0] exp_d);
		logic [11:0] f;
		logic [7:0]  r;
		int          nb;
		logic        seen;
		f = frame(d, asm_v[3], asm_v[5:4], 1'b0, nb);
		if (bad == 2'h1)
			f[nb - 2] = ~f[nb - 2];
		if (bad == 2'h2)
			f[nb - 1] = 1'b0;
		fork
			rem.send(f, nb, 128);
			wait_pulse(1, nb * 128 + 40, seen);
		join
		rd(16'hffa3, r);
		chk({seen, r[2:0]}, exp_st);
		if (rdb) begin
			rd(16'hffa2, r);
			chk(r, exp_d);
		end
	endtask

	task csi(input logic [7:0] cfg, input logic [7:0] d);
		logic [11:0] t, last, per;
		logic [7:0]  got;
		logic        s, prev, ok;
		int          i;
		wr(16'hff72, cfg);
		wr(16'hff74, d);
		i = 0;
		last = 0;
		per = 0;
		prev = 1'b1;
		ok = 1'b0;
		// External clock: bench toggles the pin every 4 cycles
		for (t = 0; t < 300 && !ok; t++) begin
			if (!cfg[1])
				sci = t[2];
			@(posedge ref_clk);
			#2;
			s = cfg[1] ? sco : sci;
			// Done pulse may stand in the cycle of the last rise
			ok = csc;
			if (s && !prev && i < 8) begin
				got[cfg[2] ? i : 7 - i] = so;
				per = t - last;
				last = t;
				i++;
			end
			prev = s;
		end
		sci = 1'b1;
		chk(got, d);
		chk(per, (cfg[4] || !cfg[1]) ? 12'h008 : 12'h004);
		chk(ok, 1'b1);
		wr(16'hff72, 8'h00);
	endtask

	// Watchdog so a stuck handshake still reaches the verdict
	initial begin
		repeat (90000) @(posedge ref_clk);
		error_cnt++;
		complete_run;
	end

	initial begin
		{bus_wr, bus_rd, bus_addr, bus_wdata, asm_v, v} = '0;
		sci = 1'b1;
		resetn = 1'b0;
		repeat (12) @(posedge ref_clk);
		#2 resetn = 1'b1;
		foreach (addrs[i]) begin
			rd(addrs[i], v);
			chk(v, 8'h00);
			wr(addrs[i], 8'hff);
			rd(addrs[i], v);
			chk(v, masks[i]);
			wr(addrs[i], 8'h00);
		end
		tx(8'h88, 8'h00, 8'ha7);
		tx(8'h98, 8'h01, 8'h5c);
		tx(8'ha8, 8'h0e, 8'h31);
		tx(8'hbc, 8'h10, 8'hc4);
		tx(8'h84, 8'h00, 8'hd3);
		wr(16'hffa1, 8'h00);
		asm_v = 8'h7c;
		wr(16'hffa0, asm_v);
		rx(8'h96, 2'h0, 1'b1, 4'h8, 8'h96);
		rx(8'h3c, 2'h1, 1'b1, 4'hc, 8'h3c);
		rx(8'h5a, 2'h2, 1'b1, 4'ha, 8'h5a);
		rx(8'h11, 2'h0, 1'b0, 4'h8, 8'h00);
		rx(8'h22, 2'h0, 1'b0, 4'h9, 8'h00);
		rx(8'h33, 2'h0, 1'b1, 4'h9, 8'h33);
		rx(8'h44, 2'h0, 1'b1, 4'h8, 8'h44);
		asm_v = 8'h6c;
		wr(16'hffa0, asm_v);
		rx(8'h96, 2'h0, 1'b1, 4'h8, 8'h96);
		asm_v = 8'h7e;
		wr(16'hffa0, asm_v);
		rx(8'h3c, 2'h1, 1'b1, 4'h4, 8'h3c);
		asm_v = 8'h54;
		wr(16'hffa0, asm_v);
		rx(8'hff, 2'h1, 1'b1, 4'h8, 8'h7f);
		wr(16'hffa0, 8'h00);
		csi(8'h82, 8'ha5);
		csi(8'h96, 8'h3c);
		csi(8'h80, 8'h6b);
		complete_run;
	end
endmodule

`default_nettype wire
